// File: hw/sflash_pkg.sv
// shared constants and types for the serial flash command front end
package sflash_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_BYTES = 3;
    localparam int ADDR_W = 24;
    localparam int ARRAY_W = 19;
    localparam logic [18:0] ARRAY_LAST = 19'h7_FFFF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] CNT_ZERO = 2'h0;

    localparam logic [7:0] OP_READ_FAST = 8'h0B;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SEQ_PROG_A = 8'hAD;
    localparam logic [7:0] OP_SEQ_PROG_B = 8'hAF;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS = 8'h04;
    localparam logic [7:0] OP_READ_PROT = 8'h3C;
    localparam logic [7:0] OP_OTP_PROG = 8'h9B;
    localparam logic [7:0] OP_OTP_READ = 8'h77;
    localparam logic [7:0] OP_STATUS_RD = 8'h05;
    localparam logic [7:0] OP_STATUS_WR1 = 8'h01;
    localparam logic [7:0] OP_STATUS_WR2 = 8'h31;
    localparam logic [7:0] OP_READ_ID = 8'h9F;
    localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] OP_RESUME = 8'hAB;

    // how a command is framed after its opcode
    typedef struct packed {
        logic known;
        logic has_addr;
        logic [1:0] dummies;
        logic is_read;
    } op_shape_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR = 3'b011,
        ST_DUMMY = 3'b010,
        ST_DATA = 3'b110,
        ST_IGNORE = 3'b111
    } dev_state_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SELECT = 3'b001,
        HS_SHIFT = 3'b011,
        HS_GAP = 3'b010,
        HS_RELEASE = 3'b110
    } host_state_t;

    function automatic op_shape_t decode_op(input logic [7:0] op);
        op_shape_t s;
        s = '{known: 1'b1, has_addr: 1'b0, dummies: 2'h0, is_read: 1'b0};
        unique case (op)
            OP_READ_FAST: begin
                s.has_addr = 1'b1;
                s.dummies = 2'h1;
                s.is_read = 1'b1;
            end
            OP_READ_SLOW: begin
                s.has_addr = 1'b1;
                s.is_read = 1'b1;
            end
            OP_PAGE_ERASE, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_PROGRAM,
            OP_SEQ_PROG_A, OP_SEQ_PROG_B, OP_READ_PROT, OP_OTP_PROG: begin
                s.has_addr = 1'b1;
            end
            OP_OTP_READ: begin
                s.has_addr = 1'b1;
                s.dummies = 2'h2;
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_WRITE_EN, OP_WRITE_DIS, OP_STATUS_RD,
            OP_STATUS_WR1, OP_STATUS_WR2, OP_READ_ID, OP_POWER_DOWN, OP_RESUME: begin
                s.known = 1'b1;
            end
            default: begin
                s.known = 1'b0;
            end
        endcase
        return s;
    endfunction : decode_op
endpackage : sflash_pkg

// File: hw/sflash_if.sv
// serial link between host master and flash front end
interface sflash_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_out;
    logic so_oe;
    logic so;

    // a released line reads as its pull-up level
    assign so = so_oe ? so_out : 1'b1;

    modport device (
        input cs_n,
        input sck,
        input si,
        output so_out,
        output so_oe
    );
    modport host (
        output cs_n,
        output sck,
        output si,
        input so
    );
endinterface : sflash_if

// File: hw/sflash_sync.sv
// three-stage synchroniser that reports a level once two late stages agree
module sflash_sync (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_async,
    input wire logic i_reset_level,
    output logic o_level
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic level_q;
    logic level_d;

    always_comb begin
        stage_d = {stage_q[1:0], i_async};
        level_d = (stage_q[2] == stage_q[1]) ? stage_q[2] : level_q;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            stage_q <= 3'h0;
            level_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    // i_reset_level is folded in after the flops via xor, keeping their reset constant
    assign o_level = level_q ^ i_reset_level;
endmodule : sflash_sync

// File: hw/sflash_device.sv
// flash front end: frames sessions, decodes opcodes, serves read array
// Function
// - host frames each operation with chip select
// - opcode byte first, then command bytes
// - all bytes shifted most significant first
// - unknown opcode ignored until reselect
// - early release before address does nothing
// - top five address bits discarded
// - read 0Bh takes dummy, 03h none
// - host picks 0Bh fast, 03h slow
// - read data shifted out after header
// - address counter advances during read
// - wrap to zero after last location
// - release ends read, output floats
// - block erases take three address bytes
// - program takes address then data
// - sequential program takes address first
// - protection read takes address, no dummy
// - otp program takes address, no dummy
// - otp read takes address, two dummies
// - status writes take one data byte
// - identification read has no address
// - resume opcode stands alone
// - sample rising clock, drive falling clock
module sflash_device
    import sflash_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    sflash_if.device bus,
    output logic [7:0] o_opcode,
    output logic o_opcode_valid,
    output logic [23:0] o_addr,
    output logic o_addr_valid,
    output logic [7:0] o_data,
    output logic o_data_valid,
    output logic [18:0] o_mem_addr,
    output logic o_mem_req,
    input wire logic [7:0] i_mem_data,
    output logic o_busy
);
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic sck_prev_q;
    logic sck_rise;
    logic sck_fall;
    logic selected;

    sflash_sync u_sync_cs (.i_clock(i_clock), .i_rst(i_rst), .i_async(~bus.cs_n),
        .i_reset_level(1'b1), .o_level(cs_n_s));
    sflash_sync u_sync_sck (.i_clock(i_clock), .i_rst(i_rst), .i_async(bus.sck),
        .i_reset_level(1'b0), .o_level(sck_s));
    sflash_sync u_sync_si (.i_clock(i_clock), .i_rst(i_rst), .i_async(bus.si),
        .i_reset_level(1'b0), .o_level(si_s));

    assign selected = ~cs_n_s;
    assign sck_rise = selected & sck_s & ~sck_prev_q;
    assign sck_fall = selected & ~sck_s & sck_prev_q;

    dev_state_t state_q, state_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic [1:0] cnt_q, cnt_d;
    op_shape_t shape_q, shape_d;
    logic [7:0] op_q, op_d;
    logic [23:0] addr_q, addr_d;
    logic [18:0] rd_addr_q, rd_addr_d;
    logic [7:0] out_q, out_d;
    logic so_q, so_d;
    logic oe_q, oe_d;
    logic op_v_q, op_v_d;
    logic addr_v_q, addr_v_d;
    logic [7:0] data_q, data_d;
    logic data_v_q, data_v_d;
    logic req_q, req_d;
    logic busy_q, busy_d;
    logic [7:0] in_byte;
    op_shape_t dec;

    assign in_byte = {shift_q[6:0], si_s};
    assign dec = decode_op(in_byte);

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        shape_d = shape_q;
        op_d = op_q;
        addr_d = addr_q;
        rd_addr_d = rd_addr_q;
        out_d = out_q;
        so_d = so_q;
        oe_d = oe_q;
        op_v_d = 1'b0;
        addr_v_d = 1'b0;
        data_d = data_q;
        data_v_d = 1'b0;
        req_d = 1'b0;
        if (!selected) begin
            // release abandons any partial command or read
            state_d = ST_IDLE;
            oe_d = 1'b0;
            bit_d = 3'h0;
        end else begin
            if (state_q == ST_IDLE) begin
                state_d = ST_OPCODE;
                bit_d = 3'h0;
            end
            if (sck_rise && state_q != ST_IGNORE && state_q != ST_DATA) begin
                shift_d = in_byte;
                bit_d = bit_q + 3'h1;
                if (bit_q == BIT_LAST) begin
                    unique case (state_q)
                        ST_IDLE, ST_OPCODE: begin
                            op_d = in_byte;
                            shape_d = dec;
                            op_v_d = dec.known;
                            cnt_d = CNT_ZERO;
                            if (!dec.known) begin
                                state_d = ST_IGNORE;
                            end else if (dec.has_addr) begin
                                state_d = ST_ADDR;
                            end else begin
                                state_d = ST_DATA;
                            end
                        end
                        ST_ADDR: begin
                            addr_d = {addr_q[15:0], in_byte};
                            cnt_d = cnt_q + 2'h1;
                            if (cnt_q == 2'(ADDR_BYTES - 1)) begin
                                addr_v_d = 1'b1;
                                rd_addr_d = {addr_q[10:0], in_byte};
                                cnt_d = CNT_ZERO;
                                state_d = (shape_q.dummies != CNT_ZERO) ? ST_DUMMY : ST_DATA;
                                req_d = shape_q.is_read;
                            end
                        end
                        ST_DUMMY: begin
                            cnt_d = cnt_q + 2'h1;
                            if (cnt_q + 2'h1 == shape_q.dummies) begin
                                state_d = ST_DATA;
                            end
                        end
                        default: begin
                            state_d = ST_IGNORE;
                        end
                    endcase
                end
            end else if (sck_rise && state_q == ST_DATA && !shape_q.is_read) begin
                // write-type payload bytes surface for the back end
                shift_d = in_byte;
                bit_d = bit_q + 3'h1;
                if (bit_q == BIT_LAST) begin
                    data_d = in_byte;
                    data_v_d = 1'b1;
                end
            end
            // the first byte is fetched before any dummy byte, so take every answer
            if (req_q) begin
                out_d = i_mem_data;
            end
            if (state_q == ST_DATA && shape_q.is_read) begin
                if (sck_fall) begin
                    oe_d = 1'b1;
                    so_d = out_q[BIT_LAST - bit_q];
                    bit_d = bit_q + 3'h1;
                    if (bit_q == BIT_LAST) begin
                        rd_addr_d = (rd_addr_q == ARRAY_LAST) ? '0 : rd_addr_q + 19'h1;
                        req_d = 1'b1;
                    end
                end
            end
        end
        busy_d = (state_d != ST_IDLE);
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            cnt_q <= 2'h0;
            shape_q <= '0;
            op_q <= 8'h00;
            addr_q <= 24'h00_0000;
            rd_addr_q <= 19'h0_0000;
            out_q <= 8'h00;
            so_q <= 1'b0;
            oe_q <= 1'b0;
            op_v_q <= 1'b0;
            addr_v_q <= 1'b0;
            data_q <= 8'h00;
            data_v_q <= 1'b0;
            req_q <= 1'b0;
            sck_prev_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            shape_q <= shape_d;
            op_q <= op_d;
            addr_q <= addr_d;
            rd_addr_q <= rd_addr_d;
            out_q <= out_d;
            so_q <= so_d;
            oe_q <= oe_d;
            op_v_q <= op_v_d;
            addr_v_q <= addr_v_d;
            data_q <= data_d;
            data_v_q <= data_v_d;
            req_q <= req_d;
            sck_prev_q <= sck_s;
            busy_q <= busy_d;
        end
    end

    assign bus.so_out = so_q;
    assign bus.so_oe = oe_q;
    assign o_opcode = op_q;
    assign o_opcode_valid = op_v_q;
    assign o_addr = addr_q;
    assign o_addr_valid = addr_v_q;
    assign o_data = data_q;
    assign o_data_valid = data_v_q;
    assign o_mem_addr = rd_addr_q;
    assign o_mem_req = req_q;
    assign o_busy = busy_q;
endmodule : sflash_device

// File: hw/sflash_host.sv
// host master: sends a header of bytes, then clocks read bytes back
module sflash_host
    import sflash_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    sflash_if.host bus,
    input wire logic i_start,
    input wire logic [7:0] i_opcode,
    input wire logic [23:0] i_addr,
    input wire logic [2:0] i_hdr_bytes,
    input wire logic [7:0] i_rd_bytes,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_busy
);
    // ten clocks per half period leave room for both synchroniser delays before the host samples
    localparam logic [3:0] HALF_CYCLES = 4'h9;
    host_state_t state_q, state_d;
    logic [3:0] div_q, div_d;
    logic [2:0] bit_q, bit_d;
    logic [2:0] hdr_q, hdr_d;
    logic [7:0] left_q, left_d;
    logic [31:0] tx_q, tx_d;
    logic [7:0] rx_q, rx_d;
    logic cs_q, cs_d, sck_q, sck_d, si_q, si_d;
    logic [7:0] rd_q, rd_d;
    logic rv_q, rv_d;
    logic busy_q, busy_d;
    logic [2:0] so_sync_q;

    always_comb begin
        state_d = state_q;
        div_d = div_q;
        bit_d = bit_q;
        hdr_d = hdr_q;
        left_d = left_q;
        tx_d = tx_q;
        rx_d = rx_q;
        cs_d = cs_q;
        sck_d = sck_q;
        si_d = si_q;
        rd_d = rd_q;
        rv_d = 1'b0;
        unique case (state_q)
            HS_IDLE: begin
                if (i_start) begin
                    tx_d = {i_opcode, i_addr};
                    hdr_d = i_hdr_bytes;
                    left_d = i_rd_bytes;
                    cs_d = 1'b0;
                    div_d = 4'h0;
                    bit_d = 3'h0;
                    state_d = HS_SELECT;
                end
            end
            HS_SELECT: begin
                si_d = tx_q[31];
                div_d = div_q + 4'h1;
                if (div_q == HALF_CYCLES) begin
                    div_d = 4'h0;
                    state_d = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                div_d = div_q + 4'h1;
                if (div_q == HALF_CYCLES) begin
                    div_d = 4'h0;
                    sck_d = ~sck_q;
                    if (!sck_q) begin
                        rx_d = {rx_q[6:0], so_sync_q[2]};
                    end else begin
                        bit_d = bit_q + 3'h1;
                        if (hdr_q != 3'h0) begin
                            tx_d = {tx_q[30:0], 1'b0};
                            si_d = tx_q[30];
                        end
                        if (bit_q == BIT_LAST) begin
                            if (hdr_q != 3'h0) begin
                                hdr_d = hdr_q - 3'h1;
                            end else begin
                                rd_d = rx_q;
                                rv_d = 1'b1;
                                left_d = left_q - 8'h01;
                            end
                            if ((hdr_q == 3'h1 && left_q == 8'h00) || (hdr_q == 3'h0 && left_q == 8'h01)) begin
                                state_d = HS_RELEASE;
                            end
                        end
                    end
                end
            end
            HS_RELEASE: begin
                cs_d = 1'b1;
                div_d = div_q + 4'h1;
                if (div_q == HALF_CYCLES) begin
                    div_d = 4'h0;
                    state_d = HS_GAP;
                end
            end
            HS_GAP: begin
                div_d = div_q + 4'h1;
                if (div_q == HALF_CYCLES) begin
                    state_d = HS_IDLE;
                end
            end
            default: begin
                state_d = HS_IDLE;
            end
        endcase
        busy_d = (state_d != HS_IDLE);
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= HS_IDLE;
            div_q <= 4'h0;
            bit_q <= 3'h0;
            hdr_q <= 3'h0;
            left_q <= 8'h00;
            tx_q <= 32'h0000_0000;
            rx_q <= 8'h00;
            cs_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
            rd_q <= 8'h00;
            rv_q <= 1'b0;
            so_sync_q <= 3'h0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            bit_q <= bit_d;
            hdr_q <= hdr_d;
            left_q <= left_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            cs_q <= cs_d;
            sck_q <= sck_d;
            si_q <= si_d;
            rd_q <= rd_d;
            rv_q <= rv_d;
            so_sync_q <= {so_sync_q[1:0], bus.so};
            busy_q <= busy_d;
        end
    end

    assign bus.cs_n = cs_q;
    assign bus.sck = sck_q;
    assign bus.si = si_q;
    assign o_rd_data = rd_q;
    assign o_rd_valid = rv_q;
    assign o_busy = busy_q;
endmodule : sflash_host

// File: verif/sflash_sva.sv
// checker on the serial link between host and flash front end
module sflash_sva (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_so_out,
    input wire logic i_so_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    property p_sel_clk_low;
        $fell(i_cs_n) |-> !i_sck;
    endproperty
    a_sel_clk_low: assert property (p_sel_clk_low) else $error("clock high at select");
    property p_idle_clk;
        i_cs_n |-> !i_sck;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock runs while deselected");
    property p_si_hold;
        i_sck |-> $stable(i_si);
    endproperty
    a_si_hold: assert property (p_si_hold) else $error("serial input moved while clock high");
    property p_clk_half;
        $rose(i_sck) |-> i_sck [*4];
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("clock high phase too short");
    property p_no_out_hdr;
        $fell(i_cs_n) |-> (!i_so_oe) [*8];
    endproperty
    a_no_out_hdr: assert property (p_no_out_hdr) else $error("output driven during opcode");
    property p_oe_sel;
        $rose(i_so_oe) |-> !i_cs_n;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("output enabled while deselected");
    property p_oe_release;
        $rose(i_cs_n) |-> ##[1:8] !i_so_oe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("output not floated after release");
    property p_oe_idle;
        i_cs_n [*8] |-> !i_so_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven in idle");
    property p_so_steady;
        i_so_oe && i_sck && $past(i_sck) && $past(i_sck, 2) |-> $stable(i_so_out);
    endproperty
    a_so_steady: assert property (p_so_steady) else $error("output changed while clock high");
endmodule : sflash_sva

// File: verif/tb.sv
// self-checking bench joining host master and flash front end
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module tb import sflash_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock, i_rst, start;
    logic [7:0] op, rd_n, mem_data, dv_op, dv_data, rd_data, shi, sho;
    logic [23:0] addr, dv_addr;
    logic [2:0] hdr;
    logic [18:0] mem_addr;
    logic dv_op_v, dv_addr_v, dv_data_v, mem_req, dv_busy, rd_v, hs_busy;
    logic [31:0] seed;
    logic [7:0] got_op[$], got_data[$], got_rd[$], wi_b[$], so_b[$];
    logic [23:0] got_addr[$];
    logic [7:0] ops_a[9] = '{OP_PAGE_ERASE, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_READ_PROT,
        OP_OTP_PROG, OP_OTP_READ, OP_SEQ_PROG_A, OP_SEQ_PROG_B};
    logic [7:0] ops_n[8] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_WRITE_EN, OP_WRITE_DIS, OP_STATUS_RD,
        OP_READ_ID, OP_POWER_DOWN, OP_RESUME};
    int n_fail, num_checks, nbits;

    sflash_if bus();
    sflash_device i_sflash_device (.i_clock(i_clock), .i_rst(i_rst), .bus(bus), .o_opcode(dv_op),
        .o_opcode_valid(dv_op_v), .o_addr(dv_addr), .o_addr_valid(dv_addr_v), .o_data(dv_data),
        .o_data_valid(dv_data_v), .o_mem_addr(mem_addr), .o_mem_req(mem_req), .i_mem_data(mem_data),
        .o_busy(dv_busy));
    sflash_host i_sflash_host (.i_clock(i_clock), .i_rst(i_rst), .bus(bus), .i_start(start), .i_opcode(op),
        .i_addr(addr), .i_hdr_bytes(hdr), .i_rd_bytes(rd_n), .o_rd_data(rd_data), .o_rd_valid(rd_v),
        .o_busy(hs_busy));
    sflash_sva i_sflash_sva (.i_clock(i_clock), .i_rst(i_rst), .i_cs_n(bus.cs_n), .i_sck(bus.sck), .i_si(bus.si),
        .i_so_out(bus.so_out), .i_so_oe(bus.so_oe));

    function automatic logic [7:0] mem_byte(input logic [18:0] a);
        return a[7:0] ^ {a[18:16], a[12:8]};
    endfunction : mem_byte

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    always @(negedge i_clock) begin
        if (dv_op_v) got_op.push_back(dv_op);
        if (dv_addr_v) got_addr.push_back(dv_addr);
        if (dv_data_v) got_data.push_back(dv_data);
        if (rd_v) got_rd.push_back(rd_data);
    end

    // array contents seen by the front end's memory port
    always @(negedge i_clock) begin
        if (mem_req) mem_data <= mem_byte(mem_addr);
    end

    // wire bytes as the far side would sample them
    always @(negedge bus.cs_n) nbits = 0;
    always @(posedge bus.sck) begin
        shi = {shi[6:0], bus.si};
        sho = {sho[6:0], bus.so};
        nbits++;
        if (nbits % 8 == 0) begin
            wi_b.push_back(shi);
            so_b.push_back(sho);
        end
    end

    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // k known opcode, ha takes address, d dummies of an array read or -1, dv payload byte expected
    task automatic run(input logic [7:0] o, input logic [23:0] a, input logic [2:0] h, input logic [7:0] r,
        input int k, input int ha, input int d, input logic [8:0] dv);
        logic [31:0] f;
        logic [18:0] p;
        f = {o, a};
        got_op.delete();
        got_addr.delete();
        got_data.delete();
        got_rd.delete();
        wi_b.delete();
        so_b.delete();
        @(negedge i_clock);
        op = o;
        addr = a;
        hdr = h;
        rd_n = r;
        start = 1'b1;
        @(negedge i_clock);
        start = 1'b0;
        while (hs_busy !== 1'b0) @(negedge i_clock);
        repeat (12) @(negedge i_clock);
        `CHK("so_oe", 1'b0, bus.so_oe)
        `CHK("busy", 1'b0, dv_busy)
        `CHK("wire_n", int'(h) + int'(r), wi_b.size())
        for (int i = 0; i < h; i++) `CHK("wire", f[31 - 8 * i -: 8], wi_b[i])
        `CHK("op_n", k, got_op.size())
        if (k != 0) `CHK("op", o, got_op[0])
        `CHK("addr_n", (k != 0 && ha != 0 && h == 4) ? 1 : 0, got_addr.size())
        if (k != 0 && ha != 0 && h == 4) `CHK("addr", a, got_addr[0])
        if (d >= 0) begin
            `CHK("rd_n", int'(r), got_rd.size())
            for (int i = d; i < r; i++) begin
                p = a[18:0] + 19'(i - d);
                `CHK("rd", mem_byte(p), got_rd[i])
                `CHK("so", mem_byte(p), so_b[h + i])
            end
        end
        if (dv[8]) begin
            `CHK("data_n", 1, got_data.size())
            `CHK("data", dv[7:0], got_data[0])
        end
    endtask : run

    initial begin
        repeat (90000) @(posedge i_clock);
        n_fail++;
        test_done();
    end

    initial begin
        i_rst = 1'b1;
        start = 1'b0;
        op = 8'h00;
        addr = 24'h00_0000;
        hdr = 3'h1;
        rd_n = 8'h00;
        mem_data = 8'h00;
        seed = 32'he392;
        repeat (16) @(negedge i_clock);
        i_rst = 1'b0;
        repeat (2) @(negedge i_clock);
        seed = xs(seed);
        run(OP_READ_SLOW, {5'h1f, seed[18:0]}, 4, 3, 1, 1, 0, 9'h000);
        run(OP_READ_FAST, 24'h07_fffe, 4, 5, 1, 1, 1, 9'h000);
        run(8'h3b, seed[23:0], 4, 2, 0, 0, -1, 9'h000);
        run(OP_READ_SLOW, seed[23:0], 4, 2, 1, 1, 0, 9'h000);
        run(OP_READ_SLOW, seed[23:0], 2, 0, 1, 1, -1, 9'h000);
        // reset lands while the front end drives read data
        hdr = 3'h4;
        rd_n = 8'h02;
        start = 1'b1;
        @(negedge i_clock);
        start = 1'b0;
        repeat (700) @(negedge i_clock);
        i_rst = 1'b1;
        repeat (4) @(negedge i_clock);
        i_rst = 1'b0;
        repeat (2) @(negedge i_clock);
        `CHK("rst_cs_n", 1'b1, bus.cs_n)
        `CHK("rst_oe", 1'b0, bus.so_oe)
        `CHK("rst_busy", 1'b0, dv_busy)
        `CHK("rst_host", 1'b0, hs_busy)
        foreach (ops_a[i]) begin
            seed = xs(seed);
            run(ops_a[i], seed[23:0], 4, 0, 1, 1, -1, 9'h000);
        end
        foreach (ops_n[i]) run(ops_n[i], seed[23:0], 1, 0, 1, 0, -1, 9'h000);
        run(OP_STATUS_WR1, seed[23:0], 2, 0, 1, 0, -1, {1'b1, seed[23:16]});
        run(OP_STATUS_WR2, seed[31:8], 2, 0, 1, 0, -1, {1'b1, seed[31:24]});
        run(OP_PROGRAM, seed[23:0], 4, 1, 1, 1, -1, 9'h100);
        test_done();
    end
endmodule : tb
